// File: asp_defs.svh
// asp_defs.svh: offsets, field positions, reset values and timing counts
// of the converter serial register port; assumes inclusion by bare name.
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// ********************************
// command byte fields
// ********************************
`define ASP_RDY_BIT     7
`define ASP_RS_HI       5
`define ASP_RS_LO       4
`define ASP_RW_BIT      3
`define ASP_RS_COMM     2'h0
`define ASP_RS_SETUP    2'h1
`define ASP_RS_DATA     2'h3

// ********************************
// reset values and lengths
// ********************************
`define ASP_COMM_RST    8'h00
`define ASP_SETUP_RST   8'h00
`define ASP_DATA_RST    16'h0000
`define ASP_BYTE_BITS   8
`define ASP_WORD_BITS   16
`define ASP_ONES_RESET  32

// ********************************
// timing
// ********************************
`define ASP_REF_NS      100
`define ASP_SCLK_NS     800
`define ASP_HALF_CYC    ((`ASP_SCLK_NS) / (2 * `ASP_REF_NS))

`endif

// File: asp_pkg.sv
// asp_pkg.sv: types shared by both ends of the serial register port.
// assumes asp_defs.svh for all numeric constants.
package asp_pkg;

  // ********************************
  // state types
  // ********************************
  typedef enum logic [1:0] {
    DST_CMD,
    DST_WR,
    DST_RD
  } asp_dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE,
    HST_SETUP,
    HST_LOW,
    HST_HIGH,
    HST_END
  } asp_host_state_t;

endpackage : asp_pkg

// File: asp_if.sv
// asp_if.sv: the serial link between host and converter port.
// assumes a pull-up on the data-out wire when nobody drives it.
`timescale 1ns/1ps

interface asp_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_drv;
  logic dout_oe;
  logic dout;
  logic conversion_ready_n;

  // ********************************
  // wire resolution
  // ********************************
  // undriven line floats high through the pull-up
  assign dout = dout_oe ? dout_drv : 1'b1;

  modport device (
    input  sclk,
    input  cs_n,
    input  din,
    output dout_drv,
    output dout_oe,
    output conversion_ready_n
  );

  modport host (
    output sclk,
    output cs_n,
    output din,
    input  dout,
    input  conversion_ready_n
  );
endinterface : asp_if

// File: asp_device.sv
// asp_device.sv: converter end of the serial register port.
// assumes link pins are asynchronous to i_ref_clk and slow against it.
//
// Contract
// - every access starts with a command write
// - after reset, wait for command write
// - command selects register and read/write
// - host writes read command, then clocks out
// - data in writes, data out reads, host clock
// - ready low when new word loaded
// - ready high after data register read
// - ready high before data register update
// - low chip select enables the port
// - rereading same word stays possible
// - ready readable as command register top bit
// - host idles serial clock high
// - chip select fall presents the first bit
// - 32 ones on data in reset port
// - port reset keeps register contents
// - shared line recovery: read 24, ones 32
// - 16-bit register: one or two transfers
// - command byte sets up next op at once
// - half duplex: no output on write, input ignored on read
// - read shifts most significant bit first
`timescale 1ns/1ps
`include "asp_defs.svh"

module asp_device
  import asp_pkg::*;
#(
  parameter int DATA_W     = 16,
  parameter int FIFO_DEPTH = 2
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  asp_if.device                  link,
  input  wire logic              i_conv_valid,
  input  wire logic [DATA_W-1:0] i_conv_data,
  output logic                   o_conv_ready,
  output logic [7:0]             o_comm,
  output logic [7:0]             o_setup,
  output logic                   o_port_reset
);

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  // ********************************
  // pin synchronisers
  // ********************************
  logic [1:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] din_s_q;
  logic       sclk_p_q;
  logic       cs_p_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_s_q <= 2'h3;
      cs_s_q   <= 2'h3;
      din_s_q  <= 2'h3;
      sclk_p_q <= 1'b1;
      cs_p_q   <= 1'b1;
    end else begin
      sclk_s_q <= {sclk_s_q[0], link.sclk};
      cs_s_q   <= {cs_s_q[0], link.cs_n};
      din_s_q  <= {din_s_q[0], link.din};
      sclk_p_q <= sclk_s_q[1];
      cs_p_q   <= cs_s_q[1];
    end
  end

  logic sel;
  logic rise;
  logic fall;
  logic cs_fall;
  logic din_b;

  assign sel     = ~cs_s_q[1];
  assign rise    = sel & sclk_s_q[1] & ~sclk_p_q;
  assign fall    = sel & ~sclk_s_q[1] & sclk_p_q;
  assign cs_fall = sel & cs_p_q;
  assign din_b   = din_s_q[1];

  // ********************************
  // resync on a run of ones
  // ********************************
  logic [5:0] ones_q;
  logic       port_rst;

  assign port_rst = rise & din_b & (ones_q == 6'(`ASP_ONES_RESET - 1));

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ones_q <= 6'h00;
    end else if (rise) begin
      ones_q <= (din_b && !port_rst) ? ones_q + 6'h01 : 6'h00;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_reset <= 1'b0;
    end else begin
      o_port_reset <= port_rst;
    end
  end

  // ********************************
  // transfer sequencer
  // ********************************
  asp_dev_state_t state_q;
  logic [1:0]     rs_q;
  logic [4:0]     cnt_q;
  logic [7:0]     shin_q;
  logic [7:0]     byte_in;
  logic [4:0]     len;
  logic           last;

  assign byte_in = {shin_q[6:0], din_b};
  // a data register phase is one 16-bit run; a pause of chip select between
  // its halves keeps the count, so two 8-bit transfers also work
  assign len  = (state_q != DST_CMD && rs_q == `ASP_RS_DATA) ?
                5'(`ASP_WORD_BITS) : 5'(`ASP_BYTE_BITS);
  assign last = rise & (cnt_q == len - 5'h01);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= DST_CMD;
      rs_q    <= `ASP_RS_COMM;
      cnt_q   <= 5'h00;
    end else if (port_rst) begin
      state_q <= DST_CMD;
      cnt_q   <= 5'h00;
    end else if (rise) begin
      if (last) begin
        cnt_q <= 5'h00;
        case (state_q)
          DST_CMD: begin
            rs_q <= byte_in[`ASP_RS_HI:`ASP_RS_LO];
            if (byte_in[`ASP_RW_BIT]) begin
              state_q <= DST_RD;
            end else if (byte_in[`ASP_RS_HI:`ASP_RS_LO] != `ASP_RS_COMM) begin
              state_q <= DST_WR;
            end else begin
              state_q <= DST_CMD;
            end
          end
          default: begin
            state_q <= DST_CMD;
          end
        endcase
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // input shifter freezes during reads
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      shin_q <= 8'h00;
    end else if (rise && state_q != DST_RD) begin
      shin_q <= byte_in;
    end
  end

  // ********************************
  // registers
  // ********************************
  logic [7:0]        comm_q;
  logic [7:0]        setup_q;
  logic [DATA_W-1:0] data_q;
  logic              ready_n_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      comm_q <= `ASP_COMM_RST;
    end else if (last && !port_rst && state_q == DST_CMD) begin
      comm_q <= {1'b0, byte_in[6:0]};
    end
  end

  // data register is read-only; writes to it are shifted and dropped
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      setup_q <= `ASP_SETUP_RST;
    end else if (last && !port_rst && state_q == DST_WR && rs_q == `ASP_RS_SETUP) begin
      setup_q <= byte_in;
    end
  end

  assign o_comm  = comm_q;
  assign o_setup = setup_q;

  // ********************************
  // read path
  // ********************************
  logic [15:0] shout_q;
  logic [15:0] rd_word;
  logic        first_q;
  logic        rose_q;
  logic        dout_q;
  logic        present;

  always_comb begin
    case (byte_in[`ASP_RS_HI:`ASP_RS_LO])
      `ASP_RS_COMM:  rd_word = {ready_n_q, comm_q[6:0], 8'h00};
      `ASP_RS_SETUP: rd_word = {setup_q, 8'h00};
      `ASP_RS_DATA:  rd_word = 16'(data_q);
      default:       rd_word = 16'h0000;
    endcase
  end

  // one shift per bit: cs fall or the first sclk fall presents the top bit
  assign present = (fall | cs_fall) & (state_q == DST_RD) & (first_q | rose_q);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      shout_q <= 16'h0000;
      first_q <= 1'b0;
      rose_q  <= 1'b0;
      dout_q  <= 1'b1;
    end else if (last && !port_rst && state_q == DST_CMD && byte_in[`ASP_RW_BIT]) begin
      shout_q <= rd_word;
      first_q <= 1'b1;
      rose_q  <= 1'b0;
    end else if (present) begin
      dout_q  <= shout_q[15];
      shout_q <= {shout_q[14:0], 1'b0};
      first_q <= 1'b0;
      rose_q  <= 1'b0;
    end else if (rise && state_q == DST_RD) begin
      rose_q  <= 1'b1;
    end
  end

  assign link.dout_drv = dout_q;
  assign link.dout_oe  = sel & (state_q == DST_RD);

  // ********************************
  // conversion buffer
  // ********************************
  logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
  logic [PW-1:0]     wp_q;
  logic [PW-1:0]     rp_q;
  logic [PW:0]       fill_q;
  logic              push;
  logic              pop;
  logic              upd_q;
  logic              busy_rd;
  logic              rd_done;

  assign o_conv_ready = (fill_q != (PW+1)'(FIFO_DEPTH));
  assign push         = i_conv_valid & o_conv_ready;
  assign pop          = upd_q;
  // hold new words back while the data register is being shifted out
  assign busy_rd      = (state_q == DST_RD) && (rs_q == `ASP_RS_DATA);
  assign rd_done      = last & ~port_rst & busy_rd;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_q   <= '0;
      rp_q   <= '0;
      fill_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PW'(FIFO_DEPTH - 1)) ? '0 : wp_q + PW'(1);
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(FIFO_DEPTH - 1)) ? '0 : rp_q + PW'(1);
      end
      fill_q <= fill_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_conv_data;
    end
  end

  // ********************************
  // data register update and ready flag
  // ********************************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      upd_q  <= 1'b0;
      data_q <= DATA_W'(`ASP_DATA_RST);
    end else if (upd_q) begin
      upd_q  <= 1'b0;
      data_q <= mem_q[rp_q];
    end else if (fill_q != '0 && !busy_rd) begin
      upd_q  <= 1'b1;
    end
  end

  // load beats completion so a fresh word is never flagged as read
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ready_n_q <= 1'b1;
    end else if (upd_q) begin
      ready_n_q <= 1'b0;
    end else if ((fill_q != '0 && !busy_rd) || rd_done) begin
      ready_n_q <= 1'b1;
    end
  end

  assign link.conversion_ready_n = ready_n_q;

endmodule : asp_device

// File: asp_host.sv
// asp_host.sv: host end of the serial register port.
// assumes i_bits in 1..32 and the device on the other side of asp_if.
`timescale 1ns/1ps
`include "asp_defs.svh"

module asp_host
  import asp_pkg::*;
#(
  parameter int HALF = `ASP_HALF_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  asp_if.host              link,
  input  wire logic        i_req,
  input  wire logic [5:0]  i_bits,
  input  wire logic [31:0] i_wdata,
  output logic             o_busy,
  output logic             o_done,
  output logic [31:0]      o_rdata,
  output logic             o_ready_n
);

  // ********************************
  // input synchronisers
  // ********************************
  logic [1:0] dout_s_q;
  logic [1:0] rdy_s_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dout_s_q <= 2'h3;
      rdy_s_q  <= 2'h3;
    end else begin
      dout_s_q <= {dout_s_q[0], link.dout};
      rdy_s_q  <= {rdy_s_q[0], link.conversion_ready_n};
    end
  end

  assign o_ready_n = rdy_s_q[1];

  // ********************************
  // frame sequencer
  // ********************************
  asp_host_state_t state_q;
  logic [7:0]      div_q;
  logic [5:0]      left_q;
  logic [31:0]     tx_q;
  logic [31:0]     rx_q;
  logic            sclk_q;
  logic            cs_n_q;
  logic            din_q;
  logic            tick;

  assign tick = (div_q == 8'(HALF - 1));

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 8'h00;
    end else if (state_q == HST_IDLE || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= HST_IDLE;
      left_q  <= 6'h00;
      tx_q    <= 32'h0000_0000;
      rx_q    <= 32'h0000_0000;
      sclk_q  <= 1'b1;
      cs_n_q  <= 1'b1;
      din_q   <= 1'b1;
      o_done  <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else begin
      o_done <= 1'b0;
      case (state_q)
        HST_IDLE: begin
          if (i_req && i_bits != 6'h00) begin
            tx_q    <= i_wdata;
            left_q  <= i_bits;
            cs_n_q  <= 1'b0;
            state_q <= HST_SETUP;
          end
        end
        HST_SETUP: begin
          if (tick) begin
            sclk_q  <= 1'b0;
            din_q   <= tx_q[31];
            tx_q    <= {tx_q[30:0], 1'b1};
            state_q <= HST_LOW;
          end
        end
        HST_LOW: begin
          if (tick) begin
            sclk_q  <= 1'b1;
            state_q <= HST_HIGH;
          end
        end
        HST_HIGH: begin
          // sample late in the high half: device output lags its sync chain
          if (tick) begin
            rx_q   <= {rx_q[30:0], dout_s_q[1]};
            left_q <= left_q - 6'h01;
            if (left_q == 6'h01) begin
              state_q <= HST_END;
            end else begin
              sclk_q  <= 1'b0;
              din_q   <= tx_q[31];
              tx_q    <= {tx_q[30:0], 1'b1};
              state_q <= HST_LOW;
            end
          end
        end
        HST_END: begin
          if (tick) begin
            cs_n_q  <= 1'b1;
            din_q   <= 1'b1;
            o_rdata <= rx_q;
            o_done  <= 1'b1;
            state_q <= HST_IDLE;
          end
        end
        default: begin
          state_q <= HST_IDLE;
        end
      endcase
    end
  end

  assign o_busy    = (state_q != HST_IDLE);
  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.din  = din_q;

endmodule : asp_host

// File: asp_assertions.sv
// asp_assertions.sv: link-side checks of the converter serial port.
// assumes the plain signals of asp_if and the 10 MHz reference clock.
`timescale 1ns/1ps

module asp_assertions (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_drv,
  input wire logic dout_oe,
  input wire logic dout,
  input wire logic conversion_ready_n
);
  logic [3:0] cs_hi_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // ****************
  // helper logic
  // ****************
  // idle count, long enough to outlast the pin synchronisers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_hi_q <= 4'h0;
    end else if (!cs_n) begin
      cs_hi_q <= 4'h0;
    end else if (cs_hi_q != 4'hF) begin
      cs_hi_q <= cs_hi_q + 4'h1;
    end
  end

  // ****************
  // properties
  // ****************
  sequence s_blink;
    conversion_ready_n ##1 !conversion_ready_n;
  endsequence
  property p_rst_idle;
    $fell(i_rst) |-> !dout_oe && conversion_ready_n;
  endproperty
  property p_desel_off;
    cs_n [*6] |-> !dout_oe;
  endproperty
  property p_oe_sel;
    $rose(dout_oe) |-> !cs_n;
  endproperty
  property p_oe_hold;
    dout_oe && !cs_n && !sclk |=> dout_oe;
  endproperty
  property p_oe_end;
    $fell(dout_oe) |-> sclk || cs_n;
  endproperty
  property p_out_fall;
    $changed(dout_drv) && dout_oe && $past(dout_oe, 2) && !cs_n |-> !sclk || !$past(sclk, 2);
  endproperty
  property p_upd_idle;
    $rose(conversion_ready_n) && cs_hi_q >= 4'h8 |-> s_blink;
  endproperty
  property p_upd_low;
    $rose(conversion_ready_n) && !sclk && !cs_n |-> s_blink;
  endproperty

  a_rst_idle:
    assert property (p_rst_idle) else $error("link not idle after reset");
  a_desel_off:
    assert property (p_desel_off) else $error("output driven while deselected");
  a_oe_sel:
    assert property (p_oe_sel) else $error("output enabled without select");
  a_oe_hold:
    assert property (p_oe_hold) else $error("output dropped mid bit");
  a_oe_end:
    assert property (p_oe_end) else $error("output released at wrong moment");
  a_out_fall:
    assert property (p_out_fall) else $error("output bit changed off falling edge");
  a_upd_idle:
    assert property (p_upd_idle) else $error("update pulse of ready wrong");
  a_upd_low:
    assert property (p_upd_low) else $error("ready rose outside read end");
endmodule : asp_assertions

// File: testbench.sv
// testbench.sv: host and converter ends joined over asp_if, compared
// with a queue model. assumes the default host divider of 800 ns.
`timescale 1ns/1ps

module testbench;
  logic        clk = 0, rst = 1, req = 0, cv = 0, busy, done, rdyn, cr, prst;
  logic [5:0]  bits = 0;
  logic [31:0] wd = 0, rd, r;
  logic [15:0] cd = 0, dreg = 0, hi;
  logic [15:0] q[$];
  logic [7:0]  comm, setup, mset;
  int          failures = 0, total_checks = 0, seed = 32'hE537, prst_seen = 0;

  asp_if link_if ();
  asp_device u_asp_device (.i_ref_clk(clk), .i_rst(rst), .link(link_if.device),
    .i_conv_valid(cv), .i_conv_data(cd), .o_conv_ready(cr), .o_comm(comm),
    .o_setup(setup), .o_port_reset(prst));
  asp_host u_asp_host (.i_ref_clk(clk), .i_rst(rst), .link(link_if.host), .i_req(req),
    .i_bits(bits), .i_wdata(wd), .o_busy(busy), .o_done(done), .o_rdata(rd),
    .o_ready_n(rdyn));
  asp_assertions u_asp_assertions (.i_ref_clk(clk), .i_rst(rst), .sclk(link_if.sclk),
    .cs_n(link_if.cs_n), .din(link_if.din), .dout_drv(link_if.dout_drv),
    .dout_oe(link_if.dout_oe), .dout(link_if.dout),
    .conversion_ready_n(link_if.conversion_ready_n));

  always #50 clk = ~clk;
  always @(posedge clk) if (prst === 1'b1) prst_seen++;

  // ****************
  // tasks
  // ****************
  task automatic summarize();
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_val(n, {15'h0, e}, {15'h0, g});
  endtask : chk_bit

  task automatic xfer(input logic [5:0] n, input logic [31:0] w);
    int k;
    @(posedge clk); #1;
    req = 1; bits = n; wd = w;
    @(posedge clk); #1;
    req = 0;
    chk_bit("busy", 1'b1, busy);
    for (k = 0; k < 4000 && done !== 1'b1; k++) begin
      @(posedge clk); #1;
    end
    if (done !== 1'b1) begin
      failures++;
      summarize();
    end
    chk_bit("busy", 1'b0, busy);
    r = rd;
  endtask : xfer

  // model: a held word moves into the data register once no read is open
  task automatic push(input logic [15:0] w, input logic open);
    @(posedge clk); #1;
    cv = 1; cd = w;
    if (cr === 1'b1) q.push_back(w);
    @(posedge clk); #1;
    cv = 0;
    if (!open && q.size() > 0) dreg = q.pop_front();
    repeat (10) @(posedge clk);
  endtask : push

  task automatic rd_data(input logic [5:0] n, input logic [31:0] w);
    xfer(n, w);
    chk_val("data", dreg, r[15:0]);
    // held words drain one after another once the read has ended
    while (q.size() > 0) dreg = q.pop_front();
    repeat (12) @(posedge clk);
  endtask : rd_data

  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    chk_val("comm", 16'h0000, {8'h00, comm});
    chk_val("setup", 16'h0000, {8'h00, setup});
    chk_bit("ready_n", 1'b1, rdyn);
    mset = 8'hA5;
    xfer(16, {8'h10, mset, 16'h0000});
    chk_val("comm", 16'h0010, {8'h00, comm});
    chk_val("setup", {8'h00, mset}, {8'h00, setup});
    for (int i = 0; i < 4; i++) begin
      mset = 8'($random(seed));
      xfer(8, {8'h10, 24'h000000});
      xfer(8, {mset, 24'h000000});
      xfer(16, {8'h18, 24'h000000});
      chk_val("setup_rd", {8'h00, mset}, {8'h00, r[7:0]});
    end
    for (int i = 0; i < 3; i++) begin
      push(16'($random(seed)), 1'b0);
      chk_bit("ready_n", 1'b0, rdyn);
      xfer(16, {8'h08, 24'h000000});
      chk_bit("ready_bit", 1'b0, r[7]);
      rd_data(24, {8'h38, 24'h000000});
      chk_bit("ready_n", 1'b1, rdyn);
      rd_data(24, {8'h38, 24'h000000});
    end
    push(16'($random(seed)), 1'b0);
    xfer(8, {8'h38, 24'h000000});
    xfer(8, 32'h00000000);
    hi = {8'h00, r[7:0]};
    xfer(8, 32'h00000000);
    chk_val("data_split", dreg, {hi[7:0], r[7:0]});
    xfer(8, {8'h38, 24'h000000});
    for (int i = 0; i < 3; i++) push(16'($random(seed)), 1'b1);
    chk_bit("conv_ready", 1'b0, cr);
    rd_data(16, 32'h00000000);
    rd_data(24, {8'h38, 24'h000000});
    rd_data(24, {8'h38, 24'h000000});
    chk_bit("conv_ready", 1'b1, cr);
    chk_val("queue", 16'h0000, 16'(q.size()));
    xfer(5, {5'b01000, 27'h0});
    xfer(24, 32'h00000000);
    prst_seen = 0;
    xfer(32, 32'hFFFFFFFF);
    chk_val("port_reset", 16'h0001, 16'(prst_seen));
    chk_val("setup", {8'h00, mset}, {8'h00, setup});
    xfer(16, {8'h18, 24'h000000});
    chk_val("setup_rd", {8'h00, mset}, {8'h00, r[7:0]});
    summarize();
  end

  initial begin
    #4_000_000;
    failures++;
    summarize();
  end
endmodule : testbench
